// >>> include/host_loss_pkg.sv
/*
 * Constants, register map and carrier types for the missing-host watchdog
 * and the rail/ground monitor configuration registers.
 * Assumes a command decoder that turns CRC-checked serial frames into
 * single-cycle register accesses and a valid-command strobe on the core clock.
 */
`default_nettype none

package host_loss_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] DEV_MON_CFG_ADDR = 8'h40;
  localparam logic [7:0] RAIL_EN_ADDR = 8'h41;
  localparam logic [7:0] RAIL_TH_ADDR = 8'h42;

  localparam logic [15:0] RAIL_EN_RESET = 16'h0000;
  localparam logic [15:0] RAIL_TH_RESET = 16'h10f0;
  localparam logic [15:0] RAIL_TH_MASK = 16'h30f0;

  localparam int POL_BIT = 2;
  localparam int WIN_LSB = 0;
  localparam logic [1:0] WIN_OFF = 2'h0;
  localparam logic [1:0] WIN_RESET = 2'h0;
  localparam logic POL_RESET = 1'b0;

  // ****************************************
  // Window lengths in diagnostic oscillator periods
  // ****************************************
  localparam int WIN1_TICKS = 5120;
  localparam int WIN2_TICKS = 10240;
  localparam int WIN3_TICKS = 20480;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic analog_rail_overvoltage_enable;
    logic analog_rail_undervoltage_enable;
    logic io_rail_overvoltage_enable;
    logic io_rail_undervoltage_enable;
    logic digital_rail_overvoltage_enable;
    logic digital_rail_undervoltage_enable;
    logic analog_rail_oscillation_enable;
    logic io_rail_oscillation_enable;
    logic digital_rail_oscillation_enable;
    logic analog_reg_overtemp_enable;
    logic io_reg_overtemp_enable;
    logic analog_reg_current_limit_enable;
    logic io_reg_current_limit_enable;
    logic analog_ground_a_disconnect_enable;
    logic analog_ground_b_disconnect_enable;
    logic digital_ground_disconnect_enable;
  } rail_enables_t;

  typedef struct packed {
    logic [1:0] unused_hi;
    logic io_rail_overvoltage_threshold;
    logic io_rail_undervoltage_threshold;
    logic [3:0] unused_mid;
    logic [1:0] analog_reg_overtemp_threshold;
    logic [1:0] io_reg_overtemp_threshold;
    logic [3:0] unused_lo;
  } rail_thresholds_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WATCH = 3'b010,
    ST_FAULT = 3'b100
  } wd_state_t;

endpackage : host_loss_pkg

`default_nettype wire

// >>> rtl/host_loss_watchdog.sv
/*
 * Missing-host watchdog with its configuration register, plus the rail and
 * ground monitor enable and threshold registers.
 * Assumes i_req arrives from the serial command decoder on the core clock,
 * i_valid_cmd pulses once per command with a correct CRC, and
 * i_diag_osc_tick pulses once per diagnostic oscillator period, all
 * already in the core clock domain.
 */
`default_nettype none

module host_loss_watchdog #(
  parameter int WIN1_TICKS = host_loss_pkg::WIN1_TICKS,
  parameter int WIN2_TICKS = host_loss_pkg::WIN2_TICKS,
  parameter int WIN3_TICKS = host_loss_pkg::WIN3_TICKS,
  parameter int CNT_W = 15
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire host_loss_pkg::reg_req_t i_req,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  input wire logic i_valid_cmd,
  input wire logic i_diag_osc_tick,
  input wire logic i_pin0_direction,
  input wire logic i_pin0_source_select,
  input wire logic i_pin0_output_format,
  output logic o_host_loss_output_pin,
  output logic o_host_loss_output_pin_oe_n,
  output logic o_host_lost,
  output host_loss_pkg::rail_enables_t o_rail_enables,
  output host_loss_pkg::rail_thresholds_t o_rail_thresholds
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (WIN1_TICKS < 2 || WIN2_TICKS < 2 || WIN3_TICKS < 2) begin : g_bad_min
    $error("Window lengths must be at least two ticks");
  end
  if (WIN3_TICKS > (1 << CNT_W) || WIN2_TICKS > (1 << CNT_W) ||
      WIN1_TICKS > (1 << CNT_W)) begin : g_bad_width
    $error("Counter too narrow for the window lengths");
  end

  // ****************************************
  // Register writes
  // ****************************************
  logic dev_wr;
  logic en_wr;
  logic th_wr;
  logic [1:0] win_wdata;
  logic [1:0] window_r;
  logic pol_r;
  logic [15:0] rail_en_r;
  logic [15:0] rail_th_r;

  assign dev_wr = i_req.wr && (i_req.addr == host_loss_pkg::DEV_MON_CFG_ADDR);
  assign en_wr = i_req.wr && (i_req.addr == host_loss_pkg::RAIL_EN_ADDR);
  assign th_wr = i_req.wr && (i_req.addr == host_loss_pkg::RAIL_TH_ADDR);
  assign win_wdata = i_req.wdata[host_loss_pkg::WIN_LSB +: 2];

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      window_r <= host_loss_pkg::WIN_RESET;
      pol_r <= host_loss_pkg::POL_RESET;
    end else if (dev_wr) begin
      window_r <= win_wdata;
      pol_r <= i_req.wdata[host_loss_pkg::POL_BIT];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rail_en_r <= host_loss_pkg::RAIL_EN_RESET;
    end else if (en_wr) begin
      rail_en_r <= i_req.wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rail_th_r <= host_loss_pkg::RAIL_TH_RESET;
    end else if (th_wr) begin
      rail_th_r <= i_req.wdata & host_loss_pkg::RAIL_TH_MASK;
    end
  end

  assign o_rail_enables = host_loss_pkg::rail_enables_t'(rail_en_r);
  assign o_rail_thresholds = host_loss_pkg::rail_thresholds_t'(rail_th_r);

  // ****************************************
  // Register reads
  // ****************************************
  logic [15:0] rdata_nxt;
  logic [15:0] rdata_r;
  logic rvalid_r;

  always_comb begin
    rdata_nxt = 16'h0000;
    case (i_req.addr)
      host_loss_pkg::DEV_MON_CFG_ADDR: begin
        // Upper bits read zero here; they live in other blocks
        rdata_nxt[host_loss_pkg::POL_BIT] = pol_r;
        rdata_nxt[host_loss_pkg::WIN_LSB +: 2] = window_r;
      end
      host_loss_pkg::RAIL_EN_ADDR: begin
        rdata_nxt = rail_en_r;
      end
      host_loss_pkg::RAIL_TH_ADDR: begin
        rdata_nxt = rail_th_r;
      end
      default: begin
        rdata_nxt = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= i_req.rd ? rdata_nxt : rdata_r;
      rvalid_r <= i_req.rd;
    end
  end

  assign o_rdata = rdata_r;
  assign o_rvalid = rvalid_r;

  // ****************************************
  // Watchdog
  // ****************************************
  host_loss_pkg::wd_state_t state_r;
  host_loss_pkg::wd_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] limit;
  logic restart;
  logic expire;

  always_comb begin
    case (window_r)
      2'h1: limit = CNT_W'(WIN1_TICKS - 1);
      2'h2: limit = CNT_W'(WIN2_TICKS - 1);
      default: limit = CNT_W'(WIN3_TICKS - 1);
    endcase
  end

  // A command in the expiring cycle was in time, so restart wins
  assign restart = i_valid_cmd || (dev_wr && win_wdata != host_loss_pkg::WIN_OFF);
  assign expire = (state_r == host_loss_pkg::ST_WATCH) && i_diag_osc_tick &&
                  (cnt_r == limit) && !restart;

  always_comb begin
    state_nxt = state_r;
    if (dev_wr && win_wdata == host_loss_pkg::WIN_OFF) begin
      state_nxt = host_loss_pkg::ST_IDLE;
    end else begin
      case (state_r)
        host_loss_pkg::ST_IDLE: begin
          if (dev_wr) begin
            state_nxt = host_loss_pkg::ST_WATCH;
          end
        end
        host_loss_pkg::ST_WATCH: begin
          if (expire) begin
            state_nxt = host_loss_pkg::ST_FAULT;
          end
        end
        host_loss_pkg::ST_FAULT: begin
          state_nxt = host_loss_pkg::ST_FAULT;
        end
        default: begin
          state_nxt = host_loss_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_r <= host_loss_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cnt_r <= '0;
    end else if (restart || state_r != host_loss_pkg::ST_WATCH) begin
      cnt_r <= '0;
    end else if (i_diag_osc_tick) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // ****************************************
  // Shared pin drive
  // ****************************************
  // Direction and source come from the pin block; host sets them first
  logic routed;
  logic level;
  logic pin_out_r;
  logic pin_oe_n_r;

  assign routed = i_pin0_direction && i_pin0_source_select;
  assign level = (state_r == host_loss_pkg::ST_FAULT) ? pol_r : ~pol_r;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pin_out_r <= 1'b0;
      pin_oe_n_r <= 1'b1;
    end else if (!routed) begin
      pin_out_r <= 1'b0;
      pin_oe_n_r <= 1'b1;
    end else if (i_pin0_output_format) begin
      pin_out_r <= 1'b0;
      pin_oe_n_r <= level;
    end else begin
      pin_out_r <= level;
      pin_oe_n_r <= 1'b0;
    end
  end

  assign o_host_loss_output_pin = pin_out_r;
  assign o_host_loss_output_pin_oe_n = pin_oe_n_r;
  assign o_host_lost = (state_r == host_loss_pkg::ST_FAULT);

  // ****************************************
  // Assertions
  // ****************************************
  property p_reserved_zero;
    @(posedge i_core_clk) disable iff (i_reset)
      i_req.rd && i_req.addr == host_loss_pkg::DEV_MON_CFG_ADDR |-> ##1
        (o_rvalid && o_rdata[7:3] == 5'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved host-loss bits read nonzero");

  property p_push_pull_level;
    @(posedge i_core_clk) disable iff (i_reset)
      routed && !i_pin0_output_format |-> ##1
        (!o_host_loss_output_pin_oe_n && o_host_loss_output_pin == $past(level));
  endproperty
  a_push_pull_level: assert property (p_push_pull_level)
    else $error("Push-pull pin level wrong for polarity");

  property p_open_drain;
    @(posedge i_core_clk) disable iff (i_reset)
      routed && i_pin0_output_format |-> ##1
        (!o_host_loss_output_pin && o_host_loss_output_pin_oe_n == $past(level));
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("Open-drain pin drives when it should release");

  property p_cmd_restart;
    @(posedge i_core_clk) disable iff (i_reset)
      state_r == host_loss_pkg::ST_WATCH && i_valid_cmd |-> ##1
        (cnt_r == '0 && state_r != host_loss_pkg::ST_FAULT);
  endproperty
  a_cmd_restart: assert property (p_cmd_restart)
    else $error("Valid command did not restart the interval");

  property p_timeout;
    @(posedge i_core_clk) disable iff (i_reset)
      state_r == host_loss_pkg::ST_WATCH && i_diag_osc_tick && cnt_r == limit &&
        !i_valid_cmd && !dev_wr |-> ##1 o_host_lost ##1
        (!$past(routed) || (o_host_loss_output_pin | o_host_loss_output_pin_oe_n) == $past(pol_r));
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("Window expiry did not assert host loss");

  property p_window_limit;
    @(posedge i_core_clk) disable iff (i_reset)
      state_r == host_loss_pkg::ST_WATCH |->
        (window_r == 2'h1 && limit == CNT_W'(WIN1_TICKS - 1)) ||
        (window_r == 2'h2 && limit == CNT_W'(WIN2_TICKS - 1)) ||
        (window_r == 2'h3 && limit == CNT_W'(WIN3_TICKS - 1));
  endproperty
  a_window_limit: assert property (p_window_limit)
    else $error("Watching with a wrong or disabled window");

  property p_clear;
    @(posedge i_core_clk) disable iff (i_reset)
      dev_wr && win_wdata == host_loss_pkg::WIN_OFF |-> ##1
        (state_r == host_loss_pkg::ST_IDLE && !o_host_lost) ##1
        (o_host_loss_output_pin_oe_n || o_host_loss_output_pin != $past(pol_r));
  endproperty
  a_clear: assert property (p_clear)
    else $error("Writing 00 did not release the host-loss output");

  property p_rail_reset;
    @(posedge i_core_clk)
      $past(i_reset) |-> rail_en_r == host_loss_pkg::RAIL_EN_RESET &&
        rail_th_r == host_loss_pkg::RAIL_TH_RESET;
  endproperty
  a_rail_reset: assert property (p_rail_reset)
    else $error("Monitor registers not at reset values");

  property p_enables_write;
    @(posedge i_core_clk) disable iff (i_reset)
      en_wr |-> ##1 o_rail_enables == host_loss_pkg::rail_enables_t'($past(i_req.wdata));
  endproperty
  a_enables_write: assert property (p_enables_write)
    else $error("Monitor enables did not take the written value");

  property p_th_reserved;
    @(posedge i_core_clk) disable iff (i_reset)
      th_wr |-> ##1 (rail_th_r & ~host_loss_pkg::RAIL_TH_MASK) == 16'h0000 &&
        (rail_th_r & host_loss_pkg::RAIL_TH_MASK) ==
        ($past(i_req.wdata) & host_loss_pkg::RAIL_TH_MASK);
  endproperty
  a_th_reserved: assert property (p_th_reserved)
    else $error("Threshold register reserved bits or fields wrong");

  property p_win_restart;
    @(posedge i_core_clk) disable iff (i_reset)
      dev_wr && win_wdata != host_loss_pkg::WIN_OFF |-> ##1 cnt_r == '0;
  endproperty
  a_win_restart: assert property (p_win_restart)
    else $error("Window write did not restart the count");

endmodule // host_loss_watchdog

`default_nettype wire

// >>> tb/host_ctrl_model.sv
/*
 * Host controller model: register writes and reads, valid-command pulses.
 * Assumes the bench supplies the core clock and calls these tasks.
 */
`default_nettype none

module host_ctrl_model (
  input wire logic i_core_clk,
  input wire logic [15:0] i_rdata,
  input wire logic i_rvalid,
  output host_loss_pkg::reg_req_t o_req,
  output logic o_valid_cmd
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_req = '0;
    o_valid_cmd = 1'b0;
  end

  // Released fields show the inverse so a stale value is never taken
  task automatic write(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_core_clk);
    o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge i_core_clk);
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic read(input logic [7:0] a, output logic [15:0] d);
    @(negedge i_core_clk);
    o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge i_core_clk);
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hffff};
    d = i_rvalid ? i_rdata : 16'hxxxx;
  endtask

  // Only a frame with a good CRC yields this pulse
  task automatic cmd();
    @(negedge i_core_clk);
    o_valid_cmd = 1'b1;
    @(negedge i_core_clk);
    o_valid_cmd = 1'b0;
  endtask

  task automatic clear();
    write(8'h40, 16'h0000);
  endtask
endmodule // host_ctrl_model

`default_nettype wire

// >>> tb/host_loss_watchdog_monitor_cfg_bench.sv
/*
 * Self-checking bench for the missing-host watchdog and rail monitor registers.
 * Assumes short window parameters; the oscillator tick comes every second cycle.
 */
`default_nettype none

module host_loss_watchdog_monitor_cfg_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W1 = 8;
  localparam int W2 = 16;
  localparam int W3 = 32;
  logic i_core_clk;
  logic i_reset;
  logic tick = 1'b0;
  logic dir = 1'b0;
  logic src = 1'b0;
  logic fmt = 1'b0;
  logic valid_cmd;
  logic rvalid;
  logic pin;
  logic pin_oe_n;
  logic lost;
  logic [15:0] rdata;
  host_loss_pkg::reg_req_t req;
  host_loss_pkg::rail_enables_t en;
  host_loss_pkg::rail_thresholds_t th;
  int fail_count = 0;
  int tests_run = 0;

  host_loss_watchdog #(.WIN1_TICKS(W1), .WIN2_TICKS(W2), .WIN3_TICKS(W3), .CNT_W(15))
  i_host_loss_watchdog (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_req(req),
    .o_rdata(rdata), .o_rvalid(rvalid), .i_valid_cmd(valid_cmd), .i_diag_osc_tick(tick),
    .i_pin0_direction(dir), .i_pin0_source_select(src), .i_pin0_output_format(fmt),
    .o_host_loss_output_pin(pin), .o_host_loss_output_pin_oe_n(pin_oe_n),
    .o_host_lost(lost), .o_rail_enables(en), .o_rail_thresholds(th));

  host_ctrl_model i_host_ctrl_model (.i_core_clk(i_core_clk), .i_rdata(rdata),
    .i_rvalid(rvalid), .o_req(req), .o_valid_cmd(valid_cmd));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    i_host_ctrl_model.read(a, d);
    chk(name, exp, d);
  endtask

  task automatic wait_lost(input int limit);
    int n;
    n = 0;
    while (lost !== 1'b1 && n < limit) begin
      @(negedge i_core_clk);
      n++;
    end
    if (lost !== 1'b1) begin
      fail_count++;
      $display("Error host_lost expected 1 seen %b", lost);
      end_of_test();
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    rdchk("cfg reset", 8'h40, 16'h0000);
    rdchk("enables reset", 8'h41, 16'h0000);
    rdchk("thresholds reset", 8'h42, 16'h10f0);
    chk("enables port", 16'h0000, en);
    chk("thresholds port", 16'h10f0, th);
    i_host_ctrl_model.write(8'h41, 16'hffff);
    rdchk("enables all", 8'h41, 16'hffff);
    i_host_ctrl_model.write(8'h41, 16'h8291);
    chk("ov osc cl gnd", 16'h000f, 16'({en.analog_rail_overvoltage_enable,
      en.analog_rail_oscillation_enable, en.analog_reg_current_limit_enable,
      en.digital_ground_disconnect_enable}));
    i_host_ctrl_model.write(8'h41, 16'h0028);
    chk("otw io cl", 16'h0003, 16'({en.io_reg_overtemp_enable,
      en.io_reg_current_limit_enable}));
    i_host_ctrl_model.write(8'h42, 16'hffff);
    rdchk("thresholds mask", 8'h42, 16'h30f0);
    chk("thresholds port mask", 16'h30f0, th);
    i_host_ctrl_model.write(8'h43, 16'hffff);
    rdchk("unmapped", 8'h43, 16'h0000);
    i_host_ctrl_model.write(8'h40, 16'h00f8);
    rdchk("cfg reserved", 8'h40, 16'h0000);
  endtask

  task automatic t_window(input logic [1:0] sel, input logic pol, input logic f,
    input logic route);
    int n;
    logic [3:0] e;
    n = (sel == 2'h1) ? W1 : (sel == 2'h2) ? W2 : W3;
    dir = 1'b1;
    src = route;
    fmt = f;
    if (!route) begin
      e = 4'b0101;
    end else if (f) begin
      e = {1'b0, ~pol, 1'b0, pol};
    end else begin
      e = {~pol, 1'b0, pol, 1'b0};
    end
    i_host_ctrl_model.write(8'h40, {13'h0000, pol, sel});
    repeat (2 * n - 2) @(negedge i_core_clk);
    chk("host_lost early", 16'h0000, 16'(lost));
    chk("pin idle", 16'(e[3:2]), 16'({pin, pin_oe_n}));
    wait_lost(2);
    @(negedge i_core_clk);
    chk("pin fault", 16'(e[1:0]), 16'({pin, pin_oe_n}));
    i_host_ctrl_model.clear();
    @(negedge i_core_clk);
    chk("host_lost cleared", 16'h0000, 16'(lost));
    chk("pin released", route ? (f ? 16'h0001 : 16'h0002) : 16'h0001, 16'({pin, pin_oe_n}));
    repeat (2 * n + 8) @(negedge i_core_clk);
    chk("host_lost disabled", 16'h0000, 16'(lost));
  endtask

  task automatic t_restart();
    i_host_ctrl_model.write(8'h40, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      repeat (10) @(negedge i_core_clk);
      i_host_ctrl_model.cmd();
    end
    chk("host_lost with commands", 16'h0000, 16'(lost));
    repeat (10) @(negedge i_core_clk);
    i_host_ctrl_model.write(8'h40, 16'h0001);
    repeat (10) @(negedge i_core_clk);
    chk("host_lost after rewrite", 16'h0000, 16'(lost));
    wait_lost(6);
    i_host_ctrl_model.clear();
  endtask

  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  always @(negedge i_core_clk) begin
    tick <= ~tick;
  end

  initial begin
    i_reset = 1'b1;
    repeat (16) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_reset = 1'b0;
    t_regs();
    for (int i = 0; i < 4; i++) begin
      t_window(2'((i % 3) + 1), i[0], i[1], 1'b1);
    end
    t_window(2'h1, 1'b0, 1'b0, 1'b0);
    t_restart();
    end_of_test();
  end
endmodule // host_loss_watchdog_monitor_cfg_bench

`default_nettype wire
